/* File: pss_strap_sampler.sv */
// Implementation choices: the address-and-strobe port and the placing of the registers.
module pss_strap_sampler
   import pss_pkg::*;
(
   input  wire logic        SYS_CLK_I,
   input  wire logic        RESET_N_I,
   // Strap-capable pins (input side of shared pins)
   input  wire logic        ADDR_STRAP_BIT0_I,
   input  wire logic [3:0]  ADDR_STRAP_UPPER_BITS_I,
   input  wire logic        AUTONEG_ENABLE_STRAP_I,
   input  wire logic        CAPABILITY_STRAP_HI_I,
   input  wire logic        CAPABILITY_STRAP_LO_I,
   // Functional values for the shared pins after reset
   input  wire logic        FUNC_COL_I,
   input  wire logic [3:0]  FUNC_RXD_I,
   input  wire logic        FUNC_ACTIVITY_I,
   input  wire logic        FUNC_SPEED_I,
   input  wire logic        FUNC_LINK_I,
   // Output side of shared pins
   output      logic        COL_PIN_O,
   output      logic        COL_PIN_OE_O,
   output      logic [3:0]  RXD_PIN_O,
   output      logic [3:0]  RXD_PIN_OE_O,
   output      logic        ACTIVITY_INDICATOR_PIN_O,
   output      logic        ACTIVITY_INDICATOR_PIN_OE_O,
   output      logic        SPEED_INDICATOR_PIN_O,
   output      logic        SPEED_INDICATOR_PIN_OE_O,
   output      logic        LINK_INDICATOR_PIN_O,
   output      logic        LINK_INDICATOR_PIN_OE_O,
   // Management address match
   input  wire logic [4:0]  MGMT_ADDR_I,
   output      logic        MGMT_ADDR_HIT_O,
   // Resulting configuration
   output      logic [4:0]  PHY_ADDR_O,
   output      logic        ISOLATE_O,
   output      logic        SPEED_100_O,
   output      logic        FULL_DUPLEX_O,
   output      logic        AUTONEG_O,
   output      logic [1:0]  ADVERTISE_CAP_O,
   // Register port
   input  wire logic [1:0]  REG_ADDR_I,
   input  wire logic [15:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output      logic [15:0] REG_RDATA_O
);

   typedef enum logic [1:0] {
      ST_SAMPLE,
      ST_SETTLE,
      ST_RUN
   } pss_state_t;

   typedef struct packed {
      pss_state_t  state;
      logic [1:0]  settle_cnt;
      pss_straps_t straps;
      logic [4:0]  phy_control_reg;
      logic        isolate;
      pss_mode_t   mode;
      logic        addr_hit;
      logic [15:0] rdata;
      logic        col;
      logic        col_oe;
      logic [3:0]  rxd;
      logic [3:0]  rxd_oe;
      logic        act;
      logic        act_oe;
      logic        spd;
      logic        spd_oe;
      logic        lnk;
      logic        lnk_oe;
   } pss_st_t;

   pss_st_t     st_q;
   pss_st_t     st_d;
   pss_straps_t pins_raw;
   pss_straps_t pins_sync;

   assign pins_raw = '{addr:    {ADDR_STRAP_UPPER_BITS_I, ADDR_STRAP_BIT0_I},
                       autoneg: AUTONEG_ENABLE_STRAP_I,
                       cap:     {CAPABILITY_STRAP_HI_I, CAPABILITY_STRAP_LO_I}};

   // Pins are asynchronous to the clock
   pss_sync2 #(
      .WIDTH ($bits(pss_straps_t))
   ) u_sync (
      .clk_i     (SYS_CLK_I),
      .reset_n_i (RESET_N_I),
      .d_i       (pins_raw),
      .q_o       (pins_sync)
   );

   // Mode decode from captured straps
   function automatic pss_mode_t decode_mode(input pss_straps_t s);
      pss_mode_t m;
      m.autoneg     = s.autoneg;
      // Forced: hi bit picks 100, lo bit picks full
      m.speed_100   = s.cap[1];
      m.full_duplex = s.cap[0];
      return m;
   endfunction : decode_mode

   // Next-state logic
   always_comb begin
      st_d          = st_q;
      st_d.addr_hit = 1'b0;
      st_d.rdata    = '0;
      unique case (st_q.state)
         ST_SAMPLE: begin
            // Reset just released; sync pipe still holds its reset zeros
            st_d.settle_cnt = SETTLE_CYC;
            st_d.state      = ST_SETTLE;
         end
         ST_SETTLE: begin
            // Capture only once the pipe holds pin samples, not its reset zeros,
            // so isolate never pulses from a stale all-zero address
            st_d.settle_cnt      = st_q.settle_cnt - 2'h1;
            if (st_q.settle_cnt == 2'h1) begin
               st_d.straps          = pins_sync;
               st_d.phy_control_reg = pins_sync.addr;
               st_d.isolate         = (pins_sync.addr == ADDR_ISOLATE);
               st_d.mode            = decode_mode(pins_sync);
               st_d.state           = ST_RUN;
            end
         end
         ST_RUN: begin
            // Pins take up their functional roles
            st_d.col    = FUNC_COL_I;
            st_d.col_oe = 1'b1;
            st_d.rxd    = FUNC_RXD_I;
            st_d.rxd_oe = 4'hf;
            st_d.act    = FUNC_ACTIVITY_I;
            st_d.act_oe = 1'b1;
            st_d.spd    = FUNC_SPEED_I;
            st_d.spd_oe = 1'b1;
            st_d.lnk    = FUNC_LINK_I;
            st_d.lnk_oe = 1'b1;
            st_d.addr_hit = (MGMT_ADDR_I == st_q.phy_control_reg);
            // Writes change the address only, never isolate
            if (REG_WR_I && REG_ADDR_I == OFS_CONTROL) begin
               st_d.phy_control_reg = REG_WDATA_I[CTL_ADDR_LSB +: ADDR_W];
            end
         end
         default: begin
            st_d.state = ST_SAMPLE;
         end
      endcase
      // Read data valid in the cycle after the strobe
      if (REG_RD_I) begin
         unique case (REG_ADDR_I)
            OFS_CONTROL: begin
               st_d.rdata[CTL_ADDR_LSB +: ADDR_W] = st_q.phy_control_reg;
               st_d.rdata[CTL_ISO_BIT]            = st_q.isolate;
            end
            OFS_STATUS: begin
               st_d.rdata[STS_SPEED_BIT]  = st_q.mode.speed_100;
               st_d.rdata[STS_DUPLEX_BIT] = st_q.mode.full_duplex;
               st_d.rdata[STS_AN_BIT]     = st_q.mode.autoneg;
               st_d.rdata[STS_ISO_BIT]    = st_q.isolate;
               st_d.rdata[STS_RUN_BIT]    = (st_q.state == ST_RUN);
            end
            OFS_STRAPS: begin
               st_d.rdata[STR_ADDR_LSB +: ADDR_W] = st_q.straps.addr;
               st_d.rdata[STR_CAP_LSB +: 2]       = st_q.straps.cap;
               st_d.rdata[STR_AN_BIT]             = st_q.straps.autoneg;
            end
            default: begin
               st_d.rdata = '0;
            end
         endcase
      end
   end

   // Reset values mirror the internal pull defaults
   always_ff @(posedge SYS_CLK_I or negedge RESET_N_I) begin
      if (!RESET_N_I) begin
         st_q                 <= '0;
         st_q.state           <= ST_SAMPLE;
         st_q.straps.addr     <= ADDR_RESET;
         st_q.straps.autoneg  <= AN_RESET;
         st_q.straps.cap      <= CAP_RESET;
         st_q.phy_control_reg <= ADDR_RESET;
         st_q.mode            <= '{speed_100: 1'b1, full_duplex: 1'b1, autoneg: AN_RESET};
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign COL_PIN_O                   = st_q.col;
   assign COL_PIN_OE_O                = st_q.col_oe;
   assign RXD_PIN_O                   = st_q.rxd;
   assign RXD_PIN_OE_O                = st_q.rxd_oe;
   assign ACTIVITY_INDICATOR_PIN_O    = st_q.act;
   assign ACTIVITY_INDICATOR_PIN_OE_O = st_q.act_oe;
   assign SPEED_INDICATOR_PIN_O       = st_q.spd;
   assign SPEED_INDICATOR_PIN_OE_O    = st_q.spd_oe;
   assign LINK_INDICATOR_PIN_O        = st_q.lnk;
   assign LINK_INDICATOR_PIN_OE_O     = st_q.lnk_oe;
   assign MGMT_ADDR_HIT_O             = st_q.addr_hit;
   assign PHY_ADDR_O                  = st_q.phy_control_reg;
   assign ISOLATE_O                   = st_q.isolate;
   assign SPEED_100_O                 = st_q.mode.speed_100;
   assign FULL_DUPLEX_O               = st_q.mode.full_duplex;
   assign AUTONEG_O                   = st_q.mode.autoneg;
   assign ADVERTISE_CAP_O             = st_q.straps.cap;
   assign REG_RDATA_O                 = st_q.rdata;
endmodule : pss_strap_sampler

/* File: pss_pkg.sv */
// Summary of operation
// - Sample strap pins shortly after reset release
// - After reset, pins return to functions
// - Latch five-bit management address at reset
// - Any address 0..31 answers management
// - Strapped address zero enters isolate mode
// - Written address zero never sets isolate
// - Unstrapped address reads 00001 by pulls
// - Autoneg strap high advertises, low forces
// - Capability straps: ground zero, supply one
package pss_pkg;

   localparam int unsigned ADDR_W        = 5;
   localparam logic [4:0]  ADDR_RESET    = 5'h01;
   localparam logic [4:0]  ADDR_ISOLATE  = 5'h00;
   localparam logic [1:0]  CAP_RESET     = 2'h3;
   localparam logic        AN_RESET      = 1'b1;
   // Register map of the small control port
   localparam logic [1:0]  OFS_CONTROL   = 2'h0;
   localparam logic [1:0]  OFS_STATUS    = 2'h1;
   localparam logic [1:0]  OFS_STRAPS    = 2'h2;
   // Control register fields
   localparam int unsigned CTL_ADDR_LSB  = 0;
   localparam int unsigned CTL_ISO_BIT   = 8;
   // Status register fields
   localparam int unsigned STS_SPEED_BIT = 0;
   localparam int unsigned STS_DUPLEX_BIT = 1;
   localparam int unsigned STS_AN_BIT    = 2;
   localparam int unsigned STS_ISO_BIT   = 3;
   localparam int unsigned STS_RUN_BIT   = 4;
   // Strap register fields
   localparam int unsigned STR_ADDR_LSB  = 0;
   localparam int unsigned STR_CAP_LSB   = 5;
   localparam int unsigned STR_AN_BIT    = 7;
   // Cycles held in settle state before the straps are captured
   localparam logic [1:0]  SETTLE_CYC    = 2'h2;

   typedef struct packed {
      logic [4:0] addr;
      logic       autoneg;
      logic [1:0] cap;
   } pss_straps_t;

   typedef struct packed {
      logic       speed_100;
      logic       full_duplex;
      logic       autoneg;
   } pss_mode_t;

endpackage : pss_pkg

/* File: pss_sync2.sv */
module pss_sync2
   import pss_pkg::*;
#(
   parameter int unsigned WIDTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             reset_n_i,
   input  wire logic [WIDTH-1:0] d_i,
   output      logic [WIDTH-1:0] q_o
);
   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } pss_sync_t;

   pss_sync_t st_q;
   pss_sync_t st_d;

   initial begin
      if (WIDTH < 1) $error("pss_sync2: WIDTH must be at least 1");
   end

   // First stage only feeds the second
   always_comb begin
      st_d    = st_q;
      st_d.s1 = d_i;
      st_d.s2 = st_q.s1;
   end

   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign q_o = st_q.s2;
endmodule : pss_sync2

/* File: pss_pull_model.sv */
module pss_pull_model
   import pss_pkg::*;
(
   input  wire logic        fit_i,
   input  wire pss_straps_t val_i,
   input  wire logic [7:0]  oe_i,
   input  wire logic [7:0]  pin_i,
   output      pss_straps_t lvl_o
);
   // Weak internal pulls when no board resistor is fitted
   localparam pss_straps_t PULL = '{addr: 5'h01, autoneg: 1'b1, cap: 2'h3};
   // Device drive wins once enabled; otherwise the resistor sets the level
   assign lvl_o = (oe_i & pin_i) | (~oe_i & (fit_i ? val_i : PULL));
endmodule : pss_pull_model

/* File: pss_sva.sv */
module pss_sva
   import pss_pkg::*;
(
   input wire logic        SYS_CLK_I,
   input wire logic        RESET_N_I,
   input wire logic [1:0]  REG_ADDR_I,
   input wire logic [15:0] REG_WDATA_I,
   input wire logic        REG_WR_I,
   input wire logic        REG_RD_I,
   input wire logic [15:0] REG_RDATA_O,
   input wire logic [4:0]  MGMT_ADDR_I,
   input wire logic        MGMT_ADDR_HIT_O,
   input wire logic [4:0]  PHY_ADDR_O,
   input wire logic        ISOLATE_O,
   input wire logic        SPEED_100_O,
   input wire logic        FULL_DUPLEX_O,
   input wire logic [1:0]  ADVERTISE_CAP_O,
   input wire logic        FUNC_COL_I,
   input wire logic [3:0]  FUNC_RXD_I,
   input wire logic        COL_PIN_O,
   input wire logic [3:0]  RXD_PIN_O,
   input wire logic        COL_PIN_OE_O
);
   default clocking @(posedge SYS_CLK_I); endclocking
   default disable iff (!RESET_N_I);
   // Pins stay released while straps settle
   sequence s_quiet;
      !COL_PIN_OE_O [*4];
   endsequence
   oe_release_a: assert property ($rose(RESET_N_I) |-> s_quiet ##1 COL_PIN_OE_O)
      else $error("pin enable timing wrong");
   pin_follow_a: assert property (COL_PIN_OE_O && $past(COL_PIN_OE_O) |->
      COL_PIN_O == $past(FUNC_COL_I) && RXD_PIN_O == $past(FUNC_RXD_I))
      else $error("pin value not functional");
   iso_hold_a: assert property (COL_PIN_OE_O && $past(COL_PIN_OE_O) |-> $stable(ISOLATE_O))
      else $error("isolate changed in run");
   hit_set_a: assert property (COL_PIN_OE_O && MGMT_ADDR_I == PHY_ADDR_O |=> MGMT_ADDR_HIT_O)
      else $error("address match missed");
   hit_cause_a: assert property (MGMT_ADDR_HIT_O |-> $past(MGMT_ADDR_I) == $past(PHY_ADDR_O))
      else $error("hit without match");
   mode_map_a: assert property (SPEED_100_O == ADVERTISE_CAP_O[1]
      && FULL_DUPLEX_O == ADVERTISE_CAP_O[0])
      else $error("speed duplex decode wrong");
   rd_idle_a: assert property (!$past(REG_RD_I) |-> REG_RDATA_O == 16'h0000)
      else $error("read data outside answer");
   rd_status_a: assert property ($past(REG_RD_I) && $past(REG_ADDR_I) == 2'h1 |->
      REG_RDATA_O[3] == $past(ISOLATE_O) && REG_RDATA_O[0] == $past(SPEED_100_O))
      else $error("status read wrong");
   wr_addr_a: assert property (REG_WR_I && REG_ADDR_I == 2'h0 && COL_PIN_OE_O |=>
      {11'h000, PHY_ADDR_O} == ($past(REG_WDATA_I) & 16'h001f))
      else $error("address write lost");
endmodule : pss_sva
bind pss_strap_sampler pss_sva u_sva (.*);

/* File: tb.sv */
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import pss_pkg::*;
   // Signals named as the ports so the block hooks up by name
   logic SYS_CLK_I = 1'b0, RESET_N_I = 1'b0, REG_WR_I = 1'b0, REG_RD_I = 1'b0, fit = 1'b0;
   logic FUNC_COL_I = 1'b0, FUNC_ACTIVITY_I = 1'b0, FUNC_SPEED_I = 1'b0, FUNC_LINK_I = 1'b0;
   logic [3:0] FUNC_RXD_I = 4'h0, ADDR_STRAP_UPPER_BITS_I, RXD_PIN_O, RXD_PIN_OE_O;
   logic ADDR_STRAP_BIT0_I, AUTONEG_ENABLE_STRAP_I, CAPABILITY_STRAP_HI_I, CAPABILITY_STRAP_LO_I;
   logic COL_PIN_O, COL_PIN_OE_O, ACTIVITY_INDICATOR_PIN_O, ACTIVITY_INDICATOR_PIN_OE_O;
   logic SPEED_INDICATOR_PIN_O, SPEED_INDICATOR_PIN_OE_O;
   logic LINK_INDICATOR_PIN_O, LINK_INDICATOR_PIN_OE_O;
   logic MGMT_ADDR_HIT_O, ISOLATE_O, SPEED_100_O, FULL_DUPLEX_O, AUTONEG_O;
   logic [4:0] MGMT_ADDR_I = 5'h00, PHY_ADDR_O;
   logic [1:0] REG_ADDR_I = 2'h0, ADVERTISE_CAP_O;
   logic [15:0] REG_WDATA_I = 16'h0000, REG_RDATA_O, rd_d;
   pss_straps_t bval = 8'h00, lvl;
   int error_cnt = 0, check_count = 0, cyc = 0;
   // Board resistors and pin sharing
   pss_pull_model board (.fit_i(fit), .val_i(bval), .lvl_o(lvl),
      .oe_i({RXD_PIN_OE_O, COL_PIN_OE_O, ACTIVITY_INDICATOR_PIN_OE_O,
             SPEED_INDICATOR_PIN_OE_O, LINK_INDICATOR_PIN_OE_O}),
      .pin_i({RXD_PIN_O, COL_PIN_O, ACTIVITY_INDICATOR_PIN_O,
              SPEED_INDICATOR_PIN_O, LINK_INDICATOR_PIN_O}));
   assign {ADDR_STRAP_UPPER_BITS_I, ADDR_STRAP_BIT0_I, AUTONEG_ENABLE_STRAP_I,
           CAPABILITY_STRAP_HI_I, CAPABILITY_STRAP_LO_I} = lvl;
   pss_strap_sampler dut (.*);
   always #5 SYS_CLK_I = ~SYS_CLK_I;
   // Cut a hang short well past the expected run length
   always @(posedge SYS_CLK_I) begin
      cyc++;
      if (cyc == 2000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   // Reset with straps held, then wait until pins are handed back
   task automatic boot(input logic f, input logic [7:0] v);
      @(posedge SYS_CLK_I);
      RESET_N_I <= 1'b0;
      fit <= f;
      bval <= v;
      repeat (3) @(posedge SYS_CLK_I);
      RESET_N_I <= 1'b1;
      repeat (6) @(posedge SYS_CLK_I);
      #1;
   endtask : boot
   task automatic wr(input logic [1:0] a, input logic [15:0] d);
      @(posedge SYS_CLK_I);
      REG_WR_I <= 1'b1;
      REG_ADDR_I <= a;
      REG_WDATA_I <= d;
      @(posedge SYS_CLK_I);
      REG_WR_I <= 1'b0;
      #1;
   endtask : wr
   task automatic rd(input logic [1:0] a);
      @(posedge SYS_CLK_I);
      REG_RD_I <= 1'b1;
      REG_ADDR_I <= a;
      @(posedge SYS_CLK_I);
      REG_RD_I <= 1'b0;
      #1 rd_d = REG_RDATA_O;
   endtask : rd
   task automatic t_default();
      boot(1'b0, 8'h00);
      chk("addr", PHY_ADDR_O, 16'h0001);
      chk("mode", {AUTONEG_O, ADVERTISE_CAP_O, SPEED_100_O, FULL_DUPLEX_O, ISOLATE_O}, 16'h003e);
      rd(2'h2);
      chk("straps", rd_d, 16'h00e1);
      rd(2'h1);
      chk("status", rd_d, 16'h0017);
      rd(2'h3);
      chk("unmapped", rd_d, 16'h0000);
      $display("test default done");
   endtask : t_default
   // All autoneg and capability codes, top address
   task automatic t_modes();
      for (int i = 0; i < 8; i++) begin
         boot(1'b1, {5'h1f, i[2:0]});
         chk("mode", {AUTONEG_O, ADVERTISE_CAP_O, SPEED_100_O, FULL_DUPLEX_O},
             {i[2:0], i[1:0]});
         chk("addr", PHY_ADDR_O, 16'h001f);
      end
      @(posedge SYS_CLK_I);
      MGMT_ADDR_I <= 5'h1f;
      @(posedge SYS_CLK_I);
      #1 chk("hit", MGMT_ADDR_HIT_O, 16'h0001);
      MGMT_ADDR_I <= 5'h1e;
      repeat (2) @(posedge SYS_CLK_I);
      #1 chk("miss", MGMT_ADDR_HIT_O, 16'h0000);
      $display("test modes done");
   endtask : t_modes
   task automatic t_isolate();
      boot(1'b1, {5'h00, 3'h7});
      chk("iso", ISOLATE_O, 16'h0001);
      wr(2'h0, 16'h0005);
      chk("addr", PHY_ADDR_O, 16'h0005);
      rd(2'h0);
      chk("ctl", rd_d, 16'h0105);
      boot(1'b1, {5'h03, 3'h7});
      wr(2'h0, 16'h0000);
      wr(2'h1, 16'h0007);
      chk("addr0", PHY_ADDR_O, 16'h0000);
      chk("iso", ISOLATE_O, 16'h0000);
      $display("test isolate done");
   endtask : t_isolate
   task automatic t_pins();
      @(posedge SYS_CLK_I);
      FUNC_RXD_I <= 4'ha;
      FUNC_COL_I <= 1'b1;
      FUNC_SPEED_I <= 1'b1;
      FUNC_LINK_I <= 1'b1;
      @(posedge SYS_CLK_I);
      #1 chk("pins", {RXD_PIN_O, COL_PIN_O, ACTIVITY_INDICATOR_PIN_O, SPEED_INDICATOR_PIN_O,
             LINK_INDICATOR_PIN_O}, 16'h00ab);
      chk("oe", {RXD_PIN_OE_O, COL_PIN_OE_O, ACTIVITY_INDICATOR_PIN_OE_O,
          SPEED_INDICATOR_PIN_OE_O, LINK_INDICATOR_PIN_OE_O}, 16'h00ff);
      $display("test pins done");
   endtask : t_pins
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : end_of_test
   initial begin
      t_default();
      t_modes();
      t_isolate();
      t_pins();
      end_of_test();
   end
endmodule : tb
